// ---- shared/mrru_pkg.sv ----
// Purpose: Shared constants for the mode register read link
// Assumes: Core clock 100 MHz, link clock made by the host divider
// Notes: Link times counted in link clocks
`default_nettype none
package mrru_pkg;
   // ----------------------------------------
   // Clocking
   // ----------------------------------------
   localparam int CORE_PERIOD_NS = 10;
   localparam int CORE_CLK_KHZ = 100000;
   localparam int CK_HALF_CYCLES = 4;
   localparam int CK_MID = CK_HALF_CYCLES / 2 - 1;
   localparam int CK_PERIOD_PS = 2 * CK_HALF_CYCLES * CORE_PERIOD_NS * 1000;
   // ----------------------------------------
   // Latencies and spacing
   // ----------------------------------------
   localparam int READ_LATENCY = 3;
   localparam int WRITE_LATENCY = 1;
   localparam int MRR_BURST = 4;
   localparam int MRR_CMD_CLKS = 2;
   localparam int DQSCK_MAX_PS = 5500;
   localparam int WTR_PS = 7500;
   localparam int DQSCK_CLKS = (DQSCK_MAX_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam int WTR_CLKS = (WTR_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam int MRR_TO_MRW_CLKS = READ_LATENCY + DQSCK_CLKS + MRR_BURST / 2 + 1;
   localparam int MRR_TO_WR_CLKS = MRR_TO_MRW_CLKS - WRITE_LATENCY;
   localparam int HOLD_W = 6;
   // ----------------------------------------
   // Command and register map
   // ----------------------------------------
   localparam logic [3:0] MRR_OPCODE = 4'h8;
   localparam logic [7:0] MR_INFO = 8'h00;
   localparam logic [7:0] MR_CFG1 = 8'h01;
   localparam logic [7:0] MR_CFG2 = 8'h02;
   localparam logic [7:0] MR_CFG3 = 8'h03;
   localparam logic [7:0] MR_TEMP = 8'h04;
   localparam logic [7:0] MR_VENDOR = 8'h05;
   localparam logic [7:0] MR_CAL_A = 8'h20;
   localparam logic [7:0] MR_CAL_B = 8'h28;
   localparam logic [7:0] INFO_RESET = 8'h00;
   localparam logic [7:0] CFG1_RESET = 8'h02;
   localparam logic [7:0] CFG2_RESET = 8'h01;
   localparam logic [7:0] CFG3_RESET = 8'h02;
   // Arbitrary vendor code
   localparam logic [7:0] VENDOR_CODE = 8'h5a;
   localparam logic [3:0] CAL_PATTERN_A = 4'h5;
   localparam logic [3:0] CAL_PATTERN_B = 4'hc;
   localparam logic [2:0] TEMP_HOT = 3'h3;
   // ----------------------------------------
   // Temperature status timing
   // ----------------------------------------
   localparam int SENSOR_UPDATE_MS = 32;
   localparam int SENSOR_UPDATE_CYCLES = SENSOR_UPDATE_MS * CORE_CLK_KHZ;
   localparam int TEMP_SLOPE_MC_PER_S = 10000;
   localparam int HOST_REACTION_MS = 1;
   localparam int THERMAL_HEADROOM_MC = 2000;
   localparam int STATUS_POLL_PERIOD_MS =
      THERMAL_HEADROOM_MC * 1000 / TEMP_SLOPE_MC_PER_S - SENSOR_UPDATE_MS - HOST_REACTION_MS;
   localparam int STATUS_POLL_CYCLES = STATUS_POLL_PERIOD_MS * CORE_CLK_KHZ;

   function automatic logic isCalAddr(input logic [7:0] a);
      return (a == MR_CAL_A) || (a == MR_CAL_B);
   endfunction
endpackage
`default_nettype wire

// ---- shared/mrru_link_if.sv ----
// Purpose: Link pins between memory device and controller
// Assumes: Device alone drives data and strobes in this block
// Notes: Undriven data and strobes read as zero
`default_nettype none
interface mrru_link_if;
   logic ck;
   logic csN;
   logic [9:0] ca;
   logic [31:0] dqOut;
   logic dqOe;
   logic [3:0] dqsOut;
   logic dqsOe;
   logic [31:0] dq;
   logic [3:0] dqs;

   assign dq = dqOe ? dqOut : 32'h0000_0000;
   assign dqs = dqsOe ? dqsOut : 4'h0;

   modport device (input ck, input csN, input ca, output dqOut, output dqOe,
      output dqsOut, output dqsOe);
   modport host (output ck, output csN, output ca, input dq, input dqs);
endinterface
`default_nettype wire

// ---- hw/mrru_device.sv ----
// Purpose: Device end of the mode register read path
// Assumes: Link clock much slower than core_clk, seen through synchronisers
// Notes: Beats change on each sampled link clock edge
`default_nettype none
module mrru_device #(
   parameter int SENSOR_UPDATE_CYCLES = mrru_pkg::SENSOR_UPDATE_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   mrru_link_if.device link,
   input wire logic [2:0] sensorCode,
   input wire logic arrayBurstActive,
   output logic mrrActive,
   output logic mrrDropped,
   output logic tempHot
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {
      DV_IDLE,
      DV_ADDR,
      DV_LAT,
      DV_BURST
   } mrru_dev_state_t;

   typedef struct packed {
      logic ckS1;
      logic ckS2;
      logic ckPrev;
      logic csNS1;
      logic csNS2;
      logic [9:0] caS1;
      logic [9:0] caS2;
      logic [2:0] sensS1;
      logic [2:0] sensS2;
      mrru_dev_state_t state;
      logic [5:0] riseHalf;
      logic [7:0] addr;
      logic [3:0] latCnt;
      logic [1:0] beat;
      logic [31:0] dq;
      logic dqs;
      logic oe;
      logic [2:0] temp;
      logic [31:0] tsiCnt;
      logic dropped;
   } mrru_dev_t;

   mrru_dev_t st_q;
   mrru_dev_t st_d;
   logic ckRise;
   logic ckFall;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   function automatic logic [7:0] regValue(input logic [7:0] a, input logic [2:0] t);
      logic [7:0] v;
      v = 8'h00;
      if (a == mrru_pkg::MR_INFO) begin
         v = mrru_pkg::INFO_RESET;
      end else if (a == mrru_pkg::MR_CFG1) begin
         v = mrru_pkg::CFG1_RESET;
      end else if (a == mrru_pkg::MR_CFG2) begin
         v = mrru_pkg::CFG2_RESET;
      end else if (a == mrru_pkg::MR_CFG3) begin
         v = mrru_pkg::CFG3_RESET;
      end else if (a == mrru_pkg::MR_TEMP) begin
         v = {5'h00, t};
      end else if (a == mrru_pkg::MR_VENDOR) begin
         v = mrru_pkg::VENDOR_CODE;
      end
      return v;
   endfunction

   function automatic logic [31:0] beatWord(input logic [7:0] a, input logic [1:0] b,
         input logic [2:0] t);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a == mrru_pkg::MR_CAL_A) begin
         w = {32{mrru_pkg::CAL_PATTERN_A[b]}};
      end else if (a == mrru_pkg::MR_CAL_B) begin
         w = {32{mrru_pkg::CAL_PATTERN_B[b]}};
      end else if (b == 2'h0) begin
         w = {24'h00_0000, regValue(a, t)};
      end
      return w;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      ckRise = st_q.ckS2 && !st_q.ckPrev;
      ckFall = !st_q.ckS2 && st_q.ckPrev;
      st_d.ckS1 = link.ck;
      st_d.ckS2 = st_q.ckS1;
      st_d.ckPrev = st_q.ckS2;
      st_d.csNS1 = link.csN;
      st_d.csNS2 = st_q.csNS1;
      st_d.caS1 = link.ca;
      st_d.caS2 = st_q.caS1;
      st_d.sensS1 = sensorCode;
      st_d.sensS2 = st_q.sensS1;
      st_d.dropped = 1'b0;

      if (st_q.tsiCnt >= 32'(SENSOR_UPDATE_CYCLES - 1)) begin
         st_d.tsiCnt = 32'h0000_0000;
         st_d.temp = st_q.sensS2;
      end else begin
         st_d.tsiCnt = st_q.tsiCnt + 32'h0000_0001;
      end

      case (st_q.state)
         DV_IDLE: begin
            if (ckRise && !st_q.csNS2 && st_q.caS2[3:0] == mrru_pkg::MRR_OPCODE) begin
               if (arrayBurstActive) begin
                  st_d.dropped = 1'b1;
               end else begin
                  st_d.riseHalf = st_q.caS2[9:4];
                  st_d.state = DV_ADDR;
               end
            end
         end
         DV_ADDR: begin
            if (ckFall) begin
               st_d.addr = {st_q.riseHalf, st_q.caS2[1:0]};
               st_d.latCnt = 4'h0;
               st_d.state = DV_LAT;
            end
         end
         DV_LAT: begin
            if (ckRise) begin
               if (st_q.latCnt == 4'(mrru_pkg::READ_LATENCY - 1)) begin
                  st_d.dq = beatWord(st_q.addr, 2'h0, st_q.temp);
                  st_d.dqs = 1'b1;
                  st_d.oe = 1'b1;
                  st_d.beat = 2'h0;
                  st_d.state = DV_BURST;
               end else begin
                  st_d.latCnt = st_q.latCnt + 4'h1;
               end
            end
         end
         DV_BURST: begin
            if (ckRise || ckFall) begin
               if (st_q.beat == 2'(mrru_pkg::MRR_BURST - 1)) begin
                  st_d.dq = 32'h0000_0000;
                  st_d.dqs = 1'b0;
                  st_d.oe = 1'b0;
                  st_d.state = DV_IDLE;
               end else begin
                  st_d.beat = st_q.beat + 2'h1;
                  st_d.dq = beatWord(st_q.addr, st_q.beat + 2'h1, st_q.temp);
                  st_d.dqs = !st_q.dqs;
               end
            end
         end
         default: begin
            st_d.state = DV_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.dqOut = st_q.dq;
   assign link.dqOe = st_q.oe;
   assign link.dqsOut = {4{st_q.dqs}};
   assign link.dqsOe = st_q.oe;
   assign mrrActive = st_q.state != DV_IDLE;
   assign mrrDropped = st_q.dropped;
   assign tempHot = st_q.temp == mrru_pkg::TEMP_HOT;
endmodule
`default_nettype wire

// ---- hw/mrru_host.sv ----
// Purpose: Controller end issuing mode register reads
// Assumes: Link clock made here by a divider of core_clk
// Notes: CA changes mid-phase so each link edge sees settled values
`default_nettype none
module mrru_host #(
   parameter int STATUS_POLL_CYCLES = mrru_pkg::STATUS_POLL_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   mrru_link_if.host link,
   input wire logic reqValid,
   input wire logic [7:0] reqAddr,
   output logic reqReady,
   input wire logic banksIdle,
   input wire logic arrayRdIssued,
   input wire logic arrayWrIssued,
   input wire logic [4:0] effBurstLen,
   output logic rdValid,
   output logic [7:0] rdData,
   output logic [3:0] calBits,
   output logic [2:0] tempCode,
   output logic tempHot,
   output logic wrAllowed,
   output logic mrwAllowed
);
   typedef enum logic [2:0] {
      HS_IDLE,
      HS_CMD_R,
      HS_CMD_E,
      HS_CMD_F,
      HS_NOPS,
      HS_WAIT
   } mrru_host_state_t;

   typedef struct packed {
      logic [2:0] divCnt;
      logic ck;
      logic csN;
      logic [9:0] ca;
      mrru_host_state_t state;
      logic [7:0] addr;
      logic isPoll;
      logic [1:0] nopCnt;
      logic [1:0] beat;
      logic dqsS1;
      logic dqsS2;
      logic dqsPrev;
      logic [31:0] dqS1;
      logic [31:0] dqS2;
      logic rdValid;
      logic [7:0] rdData;
      logic [3:0] calBits;
      logic [2:0] tempCode;
      logic [mrru_pkg::HOLD_W-1:0] wrHold;
      logic [mrru_pkg::HOLD_W-1:0] mrwHold;
      logic [mrru_pkg::HOLD_W-1:0] mrrHold;
      logic [31:0] pollCnt;
      logic pollDue;
   } mrru_host_t;

   localparam int HOLD_W = mrru_pkg::HOLD_W;

   mrru_host_t st_q;
   mrru_host_t st_d;
   logic toggle;
   logic ckRise;
   logic midLow;
   logic midHigh;
   logic dqsEdge;
   logic canIssue;
   logic takeUser;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      toggle = st_q.divCnt == 3'(mrru_pkg::CK_HALF_CYCLES - 1);
      ckRise = toggle && !st_q.ck;
      midLow = st_q.divCnt == 3'(mrru_pkg::CK_MID) && !st_q.ck;
      midHigh = st_q.divCnt == 3'(mrru_pkg::CK_MID) && st_q.ck;
      dqsEdge = st_q.dqsS2 != st_q.dqsPrev;
      canIssue = st_q.state == HS_IDLE && st_q.mrrHold == '0;
      takeUser = canIssue && reqValid
         && (!mrru_pkg::isCalAddr(reqAddr) || banksIdle);
      st_d.divCnt = toggle ? 3'h0 : st_q.divCnt + 3'h1;
      st_d.ck = toggle ? !st_q.ck : st_q.ck;
      st_d.dqsS1 = link.dqs[0];
      st_d.dqsS2 = st_q.dqsS1;
      st_d.dqsPrev = st_q.dqsS2;
      st_d.dqS1 = link.dq;
      st_d.dqS2 = st_q.dqS1;
      st_d.rdValid = 1'b0;

      if (ckRise) begin
         if (st_q.wrHold != '0) st_d.wrHold = st_q.wrHold - 1'b1;
         if (st_q.mrwHold != '0) st_d.mrwHold = st_q.mrwHold - 1'b1;
         if (st_q.mrrHold != '0) st_d.mrrHold = st_q.mrrHold - 1'b1;
      end
      if (arrayRdIssued) begin
         st_d.mrrHold = HOLD_W'(effBurstLen / 2);
      end else if (arrayWrIssued) begin
         st_d.mrrHold = HOLD_W'(mrru_pkg::WRITE_LATENCY + 1 + effBurstLen / 2
            + mrru_pkg::WTR_CLKS);
      end

      case (st_q.state)
         HS_IDLE: begin
            if (takeUser) begin
               st_d.addr = reqAddr;
               st_d.isPoll = 1'b0;
               st_d.state = HS_CMD_R;
            end else if (canIssue && st_q.pollDue) begin
               st_d.addr = mrru_pkg::MR_TEMP;
               st_d.isPoll = 1'b1;
               st_d.pollDue = 1'b0;
               st_d.state = HS_CMD_R;
            end
         end
         HS_CMD_R: begin
            if (midLow) begin
               st_d.csN = 1'b0;
               st_d.ca = {st_q.addr[7:2], mrru_pkg::MRR_OPCODE};
               st_d.state = HS_CMD_E;
            end
         end
         HS_CMD_E: begin
            if (ckRise) begin
               st_d.wrHold = HOLD_W'(mrru_pkg::MRR_TO_WR_CLKS);
               st_d.mrwHold = HOLD_W'(mrru_pkg::MRR_TO_MRW_CLKS);
               st_d.state = HS_CMD_F;
            end
         end
         HS_CMD_F: begin
            if (midHigh) begin
               st_d.ca = {8'h00, st_q.addr[1:0]};
               st_d.nopCnt = 2'h0;
               st_d.state = HS_NOPS;
            end
         end
         HS_NOPS: begin
            if (midLow) begin
               st_d.csN = 1'b1;
               st_d.ca = 10'h000;
            end
            if (ckRise) begin
               if (st_q.nopCnt == 2'(mrru_pkg::MRR_CMD_CLKS - 1)) begin
                  st_d.beat = 2'h0;
                  st_d.state = HS_WAIT;
               end else begin
                  st_d.nopCnt = st_q.nopCnt + 2'h1;
               end
            end
         end
         HS_WAIT: begin
            if (dqsEdge) begin
               st_d.calBits[st_q.beat] = st_q.dqS2[0];
               st_d.beat = st_q.beat + 2'h1;
               if (st_q.beat == 2'h0) begin
                  st_d.rdData = st_q.dqS2[7:0];
                  if (st_q.isPoll) st_d.tempCode = st_q.dqS2[2:0];
               end
               if (st_q.beat == 2'(mrru_pkg::MRR_BURST - 1)) begin
                  st_d.rdValid = 1'b1;
                  st_d.state = HS_IDLE;
               end
            end
         end
         default: begin
            st_d.state = HS_IDLE;
         end
      endcase

      // Poll timer last, so a new due flag beats a poll just started
      if (st_q.pollCnt >= 32'(STATUS_POLL_CYCLES - 1)) begin
         st_d.pollCnt = 32'h0000_0000;
         st_d.pollDue = 1'b1;
      end else begin
         st_d.pollCnt = st_q.pollCnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
         st_q.csN <= 1'b1;
         st_q.pollDue <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.ck = st_q.ck;
   assign link.csN = st_q.csN;
   assign link.ca = st_q.ca;
   assign reqReady = takeUser;
   assign rdValid = st_q.rdValid;
   assign rdData = st_q.rdData;
   assign calBits = st_q.calBits;
   assign tempCode = st_q.tempCode;
   assign tempHot = st_q.tempCode == mrru_pkg::TEMP_HOT;
   assign wrAllowed = st_q.wrHold == '0;
   assign mrwAllowed = st_q.mrwHold == '0;
endmodule
`default_nettype wire

// ---- tb/mrru_link_sva.sv ----
// Purpose: Protocol checks on the link between the two ends
// Assumes: Link clock made by the controller divider, 8 core cycles
// Notes: Helper counters measure bursts and command spacing
`default_nettype none
module mrru_link_sva (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic ck,
   input wire logic csN,
   input wire logic [9:0] ca,
   input wire logic [31:0] dqOut,
   input wire logic dqOe,
   input wire logic [3:0] dqsOut,
   input wire logic dqsOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   logic csNPrev_q;
   logic dqsPrev_q;
   logic [7:0] sinceCmd_q;
   logic [4:0] oeCyc_q;
   logic [2:0] flips_q;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         csNPrev_q <= 1'b1;
         dqsPrev_q <= 1'b0;
         sinceCmd_q <= 8'hff;
         oeCyc_q <= 5'h00;
         flips_q <= 3'h0;
      end else begin
         csNPrev_q <= csN;
         dqsPrev_q <= dqsOut[0];
         if (csNPrev_q && !csN) begin
            sinceCmd_q <= 8'h00;
         end else if (sinceCmd_q != 8'hff) begin
            sinceCmd_q <= sinceCmd_q + 8'h01;
         end
         oeCyc_q <= dqOe ? oeCyc_q + 5'h01 : 5'h00;
         if (!dqsOe) begin
            flips_q <= 3'h0;
         end else if (dqsOut[0] != dqsPrev_q) begin
            flips_q <= flips_q + 3'h1;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   AST_CMD_OPCODE: assert property ($fell(csN) |-> ca[3:0] == mrru_pkg::MRR_OPCODE)
      else $error("command code wrong at select");
   AST_CA_SETTLED: assert property ($rose(ck) |-> $stable(ca) && $stable(csN))
      else $error("command lines moved at link clock edge");
   AST_FIRST_BEAT: assert property ($rose(dqOe) |-> sinceCmd_q inside {[24:40]}
      && dqsOut == 4'hf)
      else $error("first beat at wrong time");
   AST_OE_PAIRED: assert property (dqOe == dqsOe)
      else $error("data and strobe enables differ");
   AST_DQS_ALL: assert property (dqsOe |-> dqsOut == {4{dqsOut[0]}})
      else $error("strobes not equal");
   AST_DQS_FLIPS: assert property ($fell(dqsOe) |-> flips_q == 3'h4)
      else $error("strobe toggle count wrong");
   AST_BURST_FOUR: assert property ($fell(dqOe) |-> oeCyc_q inside {[15:17]})
      else $error("burst length wrong");
   AST_CMD_ONE_CLK: assert property ($fell(csN) |-> (!csN)[*8] ##1 csN)
      else $error("select not one link clock");
   AST_NO_INTERRUPT: assert property ($fell(csN) |-> !dqOe && sinceCmd_q >= 8'h10)
      else $error("command during read");

   CV_BURST: cover property ($fell(dqOe));
   CV_CMD: cover property ($fell(csN));
   CV_ONE_BIT: cover property ($rose(dqOe) && dqOut[0]);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Both link ends joined, driven from the controller side
// Assumes: Shortened sensor and poll intervals
// Notes: Inputs change 1 ns after the rising edge
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SENSE_CYC = 50;
   localparam int POLL_CYC = 2000;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] sensorCode = 3'h0;
   logic arrayBurstActive = 1'b0;
   logic reqValid = 1'b0;
   logic [7:0] reqAddr = 8'h00;
   logic banksIdle = 1'b1;
   logic arrayRdIssued = 1'b0;
   logic arrayWrIssued = 1'b0;
   logic [4:0] effBurstLen = 5'h04;
   logic mrrActive, mrrDropped, devTempHot, reqReady, rdValid, hostTempHot;
   logic wrAllowed, mrwAllowed;
   logic [7:0] rdData;
   logic [3:0] calBits;
   logic [2:0] tempCode;
   int n_errors = 0;
   int check_count = 0;
   int lastWait;
   logic [7:0] rd;
   logic [3:0] cal;

   always #5 core_clk = ~core_clk;

   mrru_link_if link ();
   mrru_device #(.SENSOR_UPDATE_CYCLES(SENSE_CYC)) u_mrru_device (.core_clk(core_clk),
      .reset(reset), .link(link.device), .sensorCode(sensorCode),
      .arrayBurstActive(arrayBurstActive), .mrrActive(mrrActive), .mrrDropped(mrrDropped),
      .tempHot(devTempHot));
   mrru_host #(.STATUS_POLL_CYCLES(POLL_CYC)) u_mrru_host (.core_clk(core_clk),
      .reset(reset), .link(link.host), .reqValid(reqValid), .reqAddr(reqAddr),
      .reqReady(reqReady), .banksIdle(banksIdle), .arrayRdIssued(arrayRdIssued),
      .arrayWrIssued(arrayWrIssued), .effBurstLen(effBurstLen), .rdValid(rdValid),
      .rdData(rdData), .calBits(calBits), .tempCode(tempCode), .tempHot(hostTempHot),
      .wrAllowed(wrAllowed), .mrwAllowed(mrwAllowed));
   mrru_link_sva u_mrru_link_sva (.core_clk(core_clk), .reset(reset), .ck(link.ck),
      .csN(link.csN), .ca(link.ca), .dqOut(link.dqOut), .dqOe(link.dqOe),
      .dqsOut(link.dqsOut), .dqsOe(link.dqsOe));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic take(input logic [7:0] a);
      int n;
      n = 0;
      reqAddr = a;
      reqValid = 1'b1;
      #7;
      while (reqReady !== 1'b1 && n < 5000) begin
         cyc(1);
         #7;
         n++;
      end
      lastWait = n;
      @(posedge core_clk);
      #1;
      reqValid = 1'b0;
   endtask

   task automatic mrr(input logic [7:0] a);
      int n;
      n = 0;
      take(a);
      while (rdValid !== 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      chk("answer", 8'h01, {7'h00, rdValid});
      rd = rdData;
      cal = calBits;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_regs();
      logic [7:0] addrs [7] = '{mrru_pkg::MR_INFO, mrru_pkg::MR_CFG1, mrru_pkg::MR_CFG2,
         mrru_pkg::MR_CFG3, mrru_pkg::MR_VENDOR, 8'h07, 8'h3f};
      logic [7:0] exps [7] = '{mrru_pkg::INFO_RESET, mrru_pkg::CFG1_RESET,
         mrru_pkg::CFG2_RESET, mrru_pkg::CFG3_RESET, mrru_pkg::VENDOR_CODE, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++) begin
         mrr(addrs[i]);
         chk("register", exps[i], rd);
      end
   endtask

   task automatic s_cal();
      banksIdle = 1'b0;
      reqAddr = mrru_pkg::MR_CAL_A;
      reqValid = 1'b1;
      cyc(30);
      chk("busy bank pattern", 8'h00, {7'h00, reqReady});
      reqValid = 1'b0;
      banksIdle = 1'b1;
      mrr(mrru_pkg::MR_CAL_A);
      chk("pattern A", 8'h05, {4'h0, cal});
      chk("pattern A byte", 8'hff, rd);
      mrr(mrru_pkg::MR_CAL_B);
      chk("pattern B", 8'h0c, {4'h0, cal});
      chk("pattern B byte", 8'h00, rd);
   endtask

   task automatic s_spacing();
      take(mrru_pkg::MR_CFG1);
      wait (link.csN === 1'b0);
      @(posedge link.ck);
      repeat (5) @(posedge link.ck);
      #15;
      chk("spacing closed", 8'h04, {5'h00, mrrActive, wrAllowed, mrwAllowed});
      @(posedge link.ck);
      #55;
      chk("write open", 8'h02, {5'h00, mrrActive, wrAllowed, mrwAllowed});
      @(posedge link.ck);
      #55;
      chk("mode write open", 8'h03, {5'h00, mrrActive, wrAllowed, mrwAllowed});
      cyc(20);
   endtask

   task automatic s_hold(input logic isWr, input logic [4:0] len, input int bound);
      arrayRdIssued = !isWr;
      arrayWrIssued = isWr;
      effBurstLen = len;
      cyc(1);
      arrayRdIssued = 1'b0;
      arrayWrIssued = 1'b0;
      mrr(mrru_pkg::MR_CFG2);
      chk("holdoff", 8'h01, {7'h00, lastWait >= bound});
      chk("after holdoff", mrru_pkg::CFG2_RESET, rd);
   endtask

   task automatic s_temp();
      int n;
      n = 0;
      sensorCode = mrru_pkg::TEMP_HOT;
      while (tempCode !== mrru_pkg::TEMP_HOT && n < 3000) begin
         cyc(1);
         n++;
      end
      chk("polled status", 8'h03, {5'h00, tempCode});
      chk("hot flags", 8'h03, {6'h00, hostTempHot, devTempHot});
      sensorCode = 3'h1;
      cyc(SENSE_CYC + 10);
      mrr(mrru_pkg::MR_TEMP);
      chk("fresh status", 8'h01, rd);
      chk("device hot", 8'h00, {7'h00, devTempHot});
   endtask

   task automatic s_drop();
      logic seen;
      logic oe;
      logic act;
      seen = 1'b0;
      oe = 1'b0;
      act = 1'b0;
      arrayBurstActive = 1'b1;
      take(mrru_pkg::MR_CFG1);
      repeat (200) begin
         cyc(1);
         if (mrrDropped === 1'b1) seen = 1'b1;
         if (link.dqOe === 1'b1) oe = 1'b1;
         if (mrrActive === 1'b1) act = 1'b1;
      end
      chk("dropped read", 8'h04, {5'h00, seen, oe, act});
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      cyc(20);
      reset = 1'b0;
      s_regs();
      s_cal();
      s_spacing();
      s_hold(1'b0, 5'h10, 56);
      s_hold(1'b1, 5'h04, 32);
      s_hold(1'b0, 5'h08, 24);
      s_temp();
      s_drop();
      complete_run();
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      complete_run();
   end
endmodule
`default_nettype wire
